/* rtl/vczx_defs.svh */
// Constants for the voltage channel and zero-crossing block
`ifndef VCZX_DEFS_SVH
`define VCZX_DEFS_SVH
// Register offsets on the internal register port
`define VCZX_OFF_GAIN_A 8'h00
`define VCZX_OFF_GAIN_B 8'h04
`define VCZX_OFF_GAIN_C 8'h08
`define VCZX_OFF_WAVE_A 8'h0C
`define VCZX_OFF_WAVE_B 8'h10
`define VCZX_OFF_WAVE_C 8'h14
`define VCZX_OFF_TOUT 8'h18
`define VCZX_OFF_HIGHPASS_DISABLE 8'h1C
`define VCZX_OFF_CONFIG 8'h20
`define VCZX_OFF_FIRST_EVENT_REGISTER 8'h24
`define VCZX_OFF_FIRST_EVENT_ENABLE 8'h28
`define VCZX_OFF_SECOND_EVENT_REGISTER 8'h2C
`define VCZX_OFF_SECOND_EVENT_ENABLE 8'h30
// Field positions
`define VCZX_READY_BIT 17
`define VCZX_TO_LSB 3
`define VCZX_ZX_LSB 9
`define VCZX_EV_MSB 14
`define VCZX_STEER_A_LSB 8
`define VCZX_STEER_B_LSB 10
`define VCZX_STEER_C_LSB 12
// Reset values
`define VCZX_TOUT_RST 16'hFFFF
`define VCZX_CONFIG_RST 16'h0000
`define VCZX_HIGHPASS_DISABLE_RST 24'h000000
// Arithmetic constants
`define VCZX_UNITY 26'sh0800000
`define VCZX_GAIN_SHIFT 23
`define VCZX_FRAC 16
`define VCZX_HPF_SHIFT 10
// 80 Hz pole at 256 kHz: 2*pi*80/256000 is close to 2^-9
`define VCZX_LPF_SHIFT 9
// Ten percent of the 5928256 full-scale code
`define VCZX_VMIN 24'h090B3A
`define VCZX_MAX24 27'sh07FFFFF
`define VCZX_MIN24 (-27'sh0800000)
`endif

/* rtl/vczx_pkg.sv */
// Types for the voltage channel and zero-crossing block
package vczx_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } vczx_req_t;
  typedef struct packed {
    logic [2:0][23:0] ph;
  } vczx_tri_t;
endpackage : vczx_pkg

/* rtl/vczx_top.sv */
// Voltage gain, high-pass, sampling, steering and zero-crossing with timeouts
//
// Overview of operation
// - Each voltage sample is multiplied by one plus gain over two to the 23rd.
// - Scaled voltage feeds computation path outputs and the stored waveform samples.
// - Gain words travel as 32 bits: top nibble zero, sign extended to 28.
// - A high-pass filter sits in each voltage path, bypassed by the shared disable.
// - Filters run while disable holds zero, its reset value; nonzero disables all.
// - Post-filter voltage samples are stored in 24-bit waveform registers per sample.
// - Sample-ready flag in the first status register sets on each new sample set.
// - With its first mask bit set, sample-ready raises the first interrupt.
// - Waveform registers read back sign extended to 32 bits.
// - Steering field A picks A, B or C for path A; code 3 means A.
// - Steering field B picks B, C or A for path B; code 3 means B.
// - Steering field C picks C, A or B for path C; code 3 means C.
// - Crossings are taken negative to positive after a fixed 80 Hz low-pass.
// - Voltages under ten percent of full scale give no crossings; currents always do.
// - Six detectors set second status bits 9 to 14 on each crossing.
// - A crossing flag with its second mask bit set drives the second interrupt low.
// - Writing one to a second status bit clears it and releases the interrupt.
// - Each detector has a timeout counter decremented on every 16 kHz tick until it reaches zero, where it holds.
// - A crossing reloads that detector's counter from the programmed timeout.
// - Programmed timeout is 16 bits, reset to all ones.
// - Counter reaching zero sets second status bits 3 to 8.
// - A timeout flag with its second mask bit set drives the second interrupt low.
`timescale 1ns/1ps
`include "vczx_defs.svh"

module vczx_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Sample inputs, one strobe per 8 kSPS sample set
  input wire logic sample_valid_i,
  input wire vczx_pkg::vczx_tri_t volt_adc_i,
  input wire vczx_pkg::vczx_tri_t curr_i,
  // Filter and timeout ticks
  input wire logic tick_256k_i,
  input wire logic tick_16k_i,
  // Register port behind the serial interface
  input wire vczx_pkg::vczx_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  // Computation path voltages
  output vczx_pkg::vczx_tri_t volt_path_o,
  output logic volt_path_valid_o,
  // Interrupts, active low
  output logic first_interrupt_n_o,
  output logic second_interrupt_n_o
);
  import vczx_pkg::*;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers
  function automatic logic signed [23:0] sat24(input logic signed [26:0] v);
    if (v > `VCZX_MAX24) begin
      return 24'sh7FFFFF;
    end else if (v < `VCZX_MIN24) begin
      return 24'sh800000;
    end else begin
      return v[23:0];
    end
  endfunction : sat24

  function automatic logic signed [23:0] apply_gain(input logic signed [23:0] x,
                                                    input logic signed [23:0] g);
    logic signed [25:0] k;
    logic signed [49:0] p;
    k = `VCZX_UNITY + 26'(g);
    p = 50'(x) * 50'(k);
    return sat24(p[`VCZX_GAIN_SHIFT +: 27]);
  endfunction : apply_gain

  // One step of a first-order smoother with a fractional accumulator
  function automatic logic signed [39:0] smooth(input logic signed [39:0] acc,
                                                input logic signed [23:0] x,
                                                input int sh);
    logic signed [40:0] diff;
    diff = 41'($signed({x, 16'h0000})) - 41'(acc);
    return acc + 40'(diff >>> sh);
  endfunction : smooth

  function automatic logic [31:0] sext32(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction : sext32

  function automatic logic [23:0] abs24(input logic [23:0] v);
    return v[23] ? 24'(-v) : v;
  endfunction : abs24

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [23:0] gain_q [3];
  logic [23:0] wave_q [3];
  logic [15:0] tout_q;
  logic [23:0] highpass_disable_q;
  logic [15:0] config_q;
  logic ready_q;
  logic first_event_enable_q;
  logic [`VCZX_EV_MSB:`VCZX_TO_LSB] st1_q;
  logic [`VCZX_EV_MSB:`VCZX_TO_LSB] second_event_enable_q;
  logic [31:0] rdata_q;

  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [31:0] wdata;
  assign wr = reg_req_i.wr;
  assign rd = reg_req_i.rd;
  assign addr = reg_req_i.addr;
  assign wdata = reg_req_i.wdata;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_q <= '{default: 24'h000000};
      tout_q <= `VCZX_TOUT_RST;
      highpass_disable_q <= `VCZX_HIGHPASS_DISABLE_RST;
      config_q <= `VCZX_CONFIG_RST;
      first_event_enable_q <= 1'b0;
      second_event_enable_q <= '0;
    end else if (wr) begin
      case (addr)
        `VCZX_OFF_GAIN_A: gain_q[0] <= wdata[23:0];
        `VCZX_OFF_GAIN_B: gain_q[1] <= wdata[23:0];
        `VCZX_OFF_GAIN_C: gain_q[2] <= wdata[23:0];
        `VCZX_OFF_TOUT: tout_q <= wdata[15:0];
        `VCZX_OFF_HIGHPASS_DISABLE: highpass_disable_q <= wdata[23:0];
        `VCZX_OFF_CONFIG: config_q <= wdata[15:0];
        `VCZX_OFF_FIRST_EVENT_ENABLE: first_event_enable_q <= wdata[`VCZX_READY_BIT];
        `VCZX_OFF_SECOND_EVENT_ENABLE: second_event_enable_q <= wdata[`VCZX_EV_MSB:`VCZX_TO_LSB];
        default: begin
        end
      endcase
    end
  end

  // Read data, registered one cycle after the read strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= 32'h00000000;
    end else if (rd) begin
      case (addr)
        `VCZX_OFF_GAIN_A: rdata_q <= {4'h0, {4{gain_q[0][23]}}, gain_q[0]};
        `VCZX_OFF_GAIN_B: rdata_q <= {4'h0, {4{gain_q[1][23]}}, gain_q[1]};
        `VCZX_OFF_GAIN_C: rdata_q <= {4'h0, {4{gain_q[2][23]}}, gain_q[2]};
        `VCZX_OFF_WAVE_A: rdata_q <= sext32(wave_q[0]);
        `VCZX_OFF_WAVE_B: rdata_q <= sext32(wave_q[1]);
        `VCZX_OFF_WAVE_C: rdata_q <= sext32(wave_q[2]);
        `VCZX_OFF_TOUT: rdata_q <= {16'h0000, tout_q};
        `VCZX_OFF_HIGHPASS_DISABLE: rdata_q <= {8'h00, highpass_disable_q};
        `VCZX_OFF_CONFIG: rdata_q <= {16'h0000, config_q};
        `VCZX_OFF_FIRST_EVENT_REGISTER: rdata_q <= 32'(ready_q) << `VCZX_READY_BIT;
        `VCZX_OFF_FIRST_EVENT_ENABLE: rdata_q <= 32'(first_event_enable_q) << `VCZX_READY_BIT;
        `VCZX_OFF_SECOND_EVENT_REGISTER: rdata_q <= 32'(st1_q) << `VCZX_TO_LSB;
        `VCZX_OFF_SECOND_EVENT_ENABLE: rdata_q <= 32'(second_event_enable_q) << `VCZX_TO_LSB;
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign reg_rdata_o = rdata_q;

  a_wave_read_sext: assert property (
    rd && addr == `VCZX_OFF_WAVE_B |=> reg_rdata_o == {{8{$past(wave_q[1][23])}},
                                                       $past(wave_q[1])})
    else $error("waveform read not sign extended");

  ////////////////////////////////////////////////////////////////////////////
  // Gain and high-pass stage
  logic signed [23:0] gained [3];
  logic signed [23:0] filt [3];
  logic signed [39:0] dc_q [3];
  logic hpf_on;
  assign hpf_on = (highpass_disable_q == `VCZX_HIGHPASS_DISABLE_RST);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      gained[i] = apply_gain(volt_adc_i.ph[i], gain_q[i]);
      filt[i] = hpf_on ? sat24(27'(gained[i]) - 27'($signed(dc_q[i][39:`VCZX_FRAC])))
                       : gained[i];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dc_q <= '{default: 40'sh0000000000};
    end else if (sample_valid_i) begin
      for (int i = 0; i < 3; i++) begin
        dc_q[i] <= smooth(dc_q[i], gained[i], `VCZX_HPF_SHIFT);
      end
    end
  end

  // Waveform sample registers, one per phase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wave_q <= '{default: 24'h000000};
    end else if (sample_valid_i) begin
      for (int i = 0; i < 3; i++) begin
        wave_q[i] <= filt[i];
      end
    end
  end

  a_hpf_bypass: assert property (
    sample_valid_i && highpass_disable_q != 24'h000000 |=> wave_q[0] == $past(gained[0]))
    else $error("disabled filter did not pass gained sample");

  ////////////////////////////////////////////////////////////////////////////
  // Steering into the computation paths
  function automatic logic [1:0] steer(input logic [1:0] code, input logic [1:0] own);
    logic [1:0] s;
    case (code)
      2'h1: s = (own == 2'h2) ? 2'h0 : own + 2'h1;
      2'h2: s = (own == 2'h0) ? 2'h2 : own - 2'h1;
      default: s = own;
    endcase
    return s;
  endfunction : steer

  logic [1:0] sel [3];
  assign sel[0] = steer(config_q[`VCZX_STEER_A_LSB +: 2], 2'h0);
  assign sel[1] = steer(config_q[`VCZX_STEER_B_LSB +: 2], 2'h1);
  assign sel[2] = steer(config_q[`VCZX_STEER_C_LSB +: 2], 2'h2);

  vczx_tri_t path_q;
  logic path_valid_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      path_q <= '0;
      path_valid_q <= 1'b0;
    end else begin
      path_valid_q <= sample_valid_i;
      if (sample_valid_i) begin
        for (int i = 0; i < 3; i++) begin
          path_q.ph[i] <= filt[sel[i]];
        end
      end
    end
  end
  assign volt_path_o = path_q;
  assign volt_path_valid_o = path_valid_q;

  a_steer_b_from_a: assert property (
    sample_valid_i && config_q[`VCZX_STEER_B_LSB +: 2] == 2'h2
    |=> volt_path_o.ph[1] == $past(filt[0]))
    else $error("path B not fed from phase A");
  a_steer_a_code3: assert property (
    sample_valid_i && config_q[`VCZX_STEER_A_LSB +: 2] == 2'h3
    |=> volt_path_o.ph[0] == $past(filt[0]))
    else $error("code 3 did not keep phase A");

  ////////////////////////////////////////////////////////////////////////////
  // Sample-ready flag, set wins over clear
  logic ready_clr;
  assign ready_clr = wr && addr == `VCZX_OFF_FIRST_EVENT_REGISTER && wdata[`VCZX_READY_BIT];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_q <= 1'b0;
    end else if (sample_valid_i) begin
      ready_q <= 1'b1;
    end else if (ready_clr) begin
      ready_q <= 1'b0;
    end
  end
  assign first_interrupt_n_o = !(ready_q && first_event_enable_q);

  sequence s_new_sample;
    sample_valid_i && first_event_enable_q && !(wr && addr == `VCZX_OFF_FIRST_EVENT_ENABLE);
  endsequence
  a_ready_irq: assert property (
    s_new_sample |=> !first_interrupt_n_o)
    else $error("sample-ready interrupt missing");
  a_ready_set: assert property (
    sample_valid_i |=> ready_q)
    else $error("sample-ready flag not set");

  ////////////////////////////////////////////////////////////////////////////
  // Crossing low-pass filters, voltages 0..2 then currents 3..5
  logic signed [23:0] hold_q [6];
  logic signed [39:0] lpf_q [6];
  logic neg_q [6];
  logic [23:0] peak_q [3];
  logic [5:0] zx_ev;
  logic signed [39:0] lpf_nx [6];

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      lpf_nx[i] = smooth(lpf_q[i], hold_q[i], `VCZX_LPF_SHIFT);
      zx_ev[i] = tick_256k_i && neg_q[i] && !lpf_nx[i][39];
      if (i < 3) begin
        zx_ev[i] = zx_ev[i] && peak_q[i] >= `VCZX_VMIN;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_q <= '{default: 24'sh000000};
    end else if (sample_valid_i) begin
      for (int i = 0; i < 3; i++) begin
        hold_q[i] <= filt[i];
        hold_q[i + 3] <= curr_i.ph[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lpf_q <= '{default: 40'sh0000000000};
      neg_q <= '{default: 1'b0};
    end else if (tick_256k_i) begin
      for (int i = 0; i < 6; i++) begin
        lpf_q[i] <= lpf_nx[i];
        neg_q[i] <= lpf_nx[i][39];
      end
    end
  end

  // Peak magnitude since the last negative-to-positive transition
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      peak_q <= '{default: 24'h000000};
    end else if (tick_256k_i) begin
      for (int i = 0; i < 3; i++) begin
        if (neg_q[i] && !lpf_nx[i][39]) begin
          peak_q[i] <= 24'h000000;
        end else if (abs24(hold_q[i]) > peak_q[i]) begin
          peak_q[i] <= abs24(hold_q[i]);
        end
      end
    end
  end

  a_small_no_zx: assert property (
    peak_q[0] < `VCZX_VMIN |-> !zx_ev[0])
    else $error("crossing on low-amplitude voltage");
  a_curr_zx_free: assert property (
    tick_256k_i && neg_q[3] && !lpf_nx[3][39] |-> zx_ev[3])
    else $error("current crossing suppressed");

  ////////////////////////////////////////////////////////////////////////////
  // Timeout counters
  logic [15:0] cnt_q [6];
  logic [5:0] to_ev;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      to_ev[i] = tick_16k_i && !zx_ev[i] && cnt_q[i] == 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '{default: `VCZX_TOUT_RST};
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (zx_ev[i]) begin
          cnt_q[i] <= tout_q;
        end else if (tick_16k_i && cnt_q[i] != 16'h0000) begin
          cnt_q[i] <= cnt_q[i] - 16'h0001;
        end
      end
    end
  end

  a_zx_reload: assert property (
    zx_ev[4] |=> cnt_q[4] == $past(tout_q))
    else $error("counter not reloaded on crossing");
  a_tick_decrement: assert property (
    tick_16k_i && !zx_ev[1] && cnt_q[1] > 16'h0001 |=> cnt_q[1] == $past(cnt_q[1]) - 16'h0001)
    else $error("counter did not decrement on tick");
  sequence s_expired;
    cnt_q[2] == 16'h0000 && !zx_ev[2];
  endsequence
  a_expired_hold: assert property (
    s_expired |-> !to_ev[2] ##1 cnt_q[2] == 16'h0000)
    else $error("expired counter moved or reflagged");

  ////////////////////////////////////////////////////////////////////////////
  // Second status register, write one to clear, set wins
  logic [`VCZX_EV_MSB:`VCZX_TO_LSB] st1_set;
  logic [`VCZX_EV_MSB:`VCZX_TO_LSB] st1_clr;
  assign st1_set = {zx_ev, to_ev};
  assign st1_clr = (wr && addr == `VCZX_OFF_SECOND_EVENT_REGISTER) ?
                   wdata[`VCZX_EV_MSB:`VCZX_TO_LSB] : '0;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st1_q <= '0;
    end else begin
      st1_q <= st1_set | (st1_q & ~st1_clr);
    end
  end
  assign second_interrupt_n_o = !(|(st1_q & second_event_enable_q));

  sequence s_zx_masked;
    zx_ev[0] && second_event_enable_q[`VCZX_ZX_LSB] && !(wr && addr == `VCZX_OFF_SECOND_EVENT_ENABLE);
  endsequence
  a_zx_irq_low: assert property (
    s_zx_masked |=> !second_interrupt_n_o)
    else $error("crossing did not pull interrupt low");
  a_to_irq_low: assert property (
    to_ev[5] && second_event_enable_q[`VCZX_TO_LSB + 5] && !(wr && addr == `VCZX_OFF_SECOND_EVENT_ENABLE)
    |=> !second_interrupt_n_o && st1_q[`VCZX_TO_LSB + 5])
    else $error("timeout did not pull interrupt low");
  a_w1c_clear: assert property (
    st1_clr[`VCZX_ZX_LSB + 1] && !st1_set[`VCZX_ZX_LSB + 1] |=> !st1_q[`VCZX_ZX_LSB + 1])
    else $error("status bit not cleared by write");
  a_set_wins: assert property (
    st1_clr[`VCZX_TO_LSB] && st1_set[`VCZX_TO_LSB] |=> st1_q[`VCZX_TO_LSB])
    else $error("event lost against clear");
endmodule : vczx_top

/* verif/testbench.sv */
// Self-checking bench for the voltage channel and zero-crossing block
`timescale 1ns/1ps
`include "vczx_defs.svh"

module testbench;
  import vczx_pkg::*;
  logic clk_i;
  logic reset_n_i;
  logic sample_valid_i;
  logic tick_256k_i;
  logic tick_16k_i;
  vczx_tri_t volt_adc_i;
  vczx_tri_t curr_i;
  vczx_req_t reg_req;
  logic [31:0] reg_rdata;
  vczx_tri_t volt_path;
  logic path_valid;
  logic irq0_n;
  logic second_interrupt_n_n;
  logic [31:0] d;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;

  vczx_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sample_valid_i(sample_valid_i),
    .volt_adc_i(volt_adc_i), .curr_i(curr_i), .tick_256k_i(tick_256k_i),
    .tick_16k_i(tick_16k_i), .reg_req_i(reg_req), .reg_rdata_o(reg_rdata),
    .volt_path_o(volt_path), .volt_path_valid_o(path_valid),
    .first_interrupt_n_o(irq0_n), .second_interrupt_n_o(second_interrupt_n_n));

  vczx_host u_host (.clk_i(clk_i), .reg_req_o(reg_req), .reg_rdata_i(reg_rdata));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Samples and filter steps on every edge for n cycles
  task automatic pulse(input int n);
    @(negedge clk_i);
    sample_valid_i = 1'b1;
    tick_256k_i = 1'b1;
    repeat (n) @(negedge clk_i);
    sample_valid_i = 1'b0;
    tick_256k_i = 1'b0;
  endtask : pulse

  task automatic tick16();
    @(negedge clk_i);
    tick_16k_i = 1'b1;
    @(negedge clk_i);
    tick_16k_i = 1'b0;
  endtask : tick16

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    u_host.rd(`VCZX_OFF_TOUT, d);
    chk(d, 32'h0000FFFF, "timeout load reset");
    u_host.rd(`VCZX_OFF_HIGHPASS_DISABLE, d);
    chk(d, 32'h00000000, "filter disable reset");
    u_host.rd(`VCZX_OFF_CONFIG, d);
    chk(d, 32'h00000000, "steering reset");
    u_host.wr(`VCZX_OFF_WAVE_A, 32'h00123456);
    u_host.rd(`VCZX_OFF_WAVE_A, d);
    chk(d, 32'h00000000, "sample is read-only");
    u_host.rd(8'h7C, d);
    chk(d, 32'h00000000, "unmapped read");
    chk({31'h0, second_interrupt_n_n}, 32'h1, "second irq idle");
  endtask : t_reset

  task automatic t_zx();
    u_host.wr(`VCZX_OFF_HIGHPASS_DISABLE, 32'h00000001);
    u_host.wr(`VCZX_OFF_TOUT, 32'h00000005);
    u_host.wr(`VCZX_OFF_SECOND_EVENT_ENABLE, 32'h00001340);
    volt_adc_i.ph = {24'hE00000, 24'hFC0000, 24'hE00000};
    curr_i.ph = {3{24'hF00000}};
    pulse(2000);
    u_host.rd(`VCZX_OFF_SECOND_EVENT_REGISTER, d);
    chk(d, 32'h00000000, "falling gives no crossing");
    volt_adc_i.ph = {24'h200000, 24'h040000, 24'h200000};
    curr_i.ph = {3{24'h100000}};
    pulse(2000);
    u_host.rd(`VCZX_OFF_SECOND_EVENT_REGISTER, d);
    chk(d, 32'h00007A00, "crossing flags, small B silent");
    chk({31'h0, second_interrupt_n_n}, 32'h0, "crossing irq");
    u_host.clr1(32'h00007E00);
    chk({31'h0, second_interrupt_n_n}, 32'h1, "irq released");
    u_host.rd(`VCZX_OFF_SECOND_EVENT_REGISTER, d);
    chk(d, 32'h00000000, "flags cleared");
  endtask : t_zx

  task automatic t_tout();
    repeat (4) tick16();
    u_host.rd(`VCZX_OFF_SECOND_EVENT_REGISTER, d);
    chk(d, 32'h00000000, "no early timeout");
    tick16();
    chk({31'h0, second_interrupt_n_n}, 32'h0, "timeout irq");
    u_host.rd(`VCZX_OFF_SECOND_EVENT_REGISTER, d);
    chk(d, 32'h000001E8, "timeout flags");
    u_host.clr1(32'h000001E8);
    repeat (3) tick16();
    u_host.rd(`VCZX_OFF_SECOND_EVENT_REGISTER, d);
    chk(d, 32'h00000000, "expired counter flags once");
    chk({31'h0, second_interrupt_n_n}, 32'h1, "irq stays high");
  endtask : t_tout

  task automatic t_gain();
    u_host.wgain(`VCZX_OFF_GAIN_A, 24'h400000);
    u_host.wgain(`VCZX_OFF_GAIN_B, 24'hC00000);
    u_host.rd(`VCZX_OFF_GAIN_B, d);
    chk(d, 32'h0FC00000, "gain word form");
    u_host.wr(`VCZX_OFF_FIRST_EVENT_REGISTER, 32'h00020000);
    u_host.wr(`VCZX_OFF_FIRST_EVENT_ENABLE, 32'h00020000);
    chk({31'h0, irq0_n}, 32'h1, "first irq idle");
    volt_adc_i.ph = {24'hF00000, 24'h100000, 24'h100000};
    pulse(1);
    chk({31'h0, path_valid}, 32'h1, "path valid");
    chk(volt_path.ph[0], 32'h00180000, "plus half");
    chk(volt_path.ph[1], 32'h00080000, "minus half");
    chk(volt_path.ph[2], 32'h00F00000, "unity");
    chk({31'h0, irq0_n}, 32'h0, "ready irq");
    u_host.rd(`VCZX_OFF_WAVE_A, d);
    chk(d, 32'h00180000, "sample A");
    u_host.rd(`VCZX_OFF_WAVE_B, d);
    chk(d, 32'h00080000, "sample B");
    u_host.rd(`VCZX_OFF_WAVE_C, d);
    chk(d, 32'hFFF00000, "sample C extended");
    u_host.rd(`VCZX_OFF_FIRST_EVENT_REGISTER, d);
    chk(d, 32'h00020000, "ready flag");
    u_host.wr(`VCZX_OFF_FIRST_EVENT_REGISTER, 32'h00020000);
    chk({31'h0, irq0_n}, 32'h1, "ready cleared");
    u_host.wgain(`VCZX_OFF_GAIN_A, 24'h000000);
    u_host.wgain(`VCZX_OFF_GAIN_B, 24'h000000);
  endtask : t_gain

  task automatic t_steer();
    int s;
    volt_adc_i.ph = {24'h300000, 24'h200000, 24'h100000};
    for (int k = 0; k < 4; k++) begin
      u_host.wr(`VCZX_OFF_CONFIG, 32'(k * 32'h1500));
      pulse(1);
      for (int p = 0; p < 3; p++) begin
        s = (k == 3) ? p : (p + k) % 3;
        chk(volt_path.ph[p], volt_adc_i.ph[s], "steer");
      end
    end
  endtask : t_steer

  task automatic t_hpf();
    u_host.wr(`VCZX_OFF_HIGHPASS_DISABLE, 32'h00000000);
    volt_adc_i.ph = {3{24'h100000}};
    pulse(4000);
    u_host.rd(`VCZX_OFF_WAVE_A, d);
    chk({31'h0, (d[31] ? ~d + 32'h1 : d) < 32'h00020000}, 32'h1, "offset removed");
  endtask : t_hpf

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    sample_valid_i = 1'b0;
    tick_256k_i = 1'b0;
    tick_16k_i = 1'b0;
    volt_adc_i = '0;
    curr_i = '0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    t_reset();
    t_zx();
    t_tout();
    t_gain();
    t_steer();
    t_hpf();
    close_out();
  end
endmodule : testbench

/* verif/vczx_host.sv */
// Host model that reaches the block through its register port
`timescale 1ns/1ps
`include "vczx_defs.svh"

module vczx_host (
  // Clock
  input wire logic clk_i,
  // Register port
  output vczx_pkg::vczx_req_t reg_req_o,
  input wire logic [31:0] reg_rdata_i
);
  import vczx_pkg::*;

  initial begin
    reg_req_o = '0;
  end

  // Released port shows inverted leftovers, never the last request
  task automatic release_port();
    reg_req_o.wr = 1'b0;
    reg_req_o.rd = 1'b0;
    reg_req_o.addr = ~reg_req_o.addr;
    reg_req_o.wdata = ~reg_req_o.wdata;
  endtask : release_port

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clk_i);
    reg_req_o.addr = a;
    reg_req_o.wdata = v;
    reg_req_o.wr = 1'b1;
    @(negedge clk_i);
    release_port();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clk_i);
    reg_req_o.addr = a;
    reg_req_o.rd = 1'b1;
    @(negedge clk_i);
    v = reg_rdata_i;
    release_port();
  endtask : rd

  // Gain words go out with a zero top nibble and sign extended to 28 bits
  task automatic wgain(input logic [7:0] a, input logic [23:0] g);
    wr(a, {4'h0, {4{g[23]}}, g});
  endtask : wgain

  // Flags are cleared by writing ones to them
  task automatic clr1(input logic [31:0] bits);
    wr(`VCZX_OFF_SECOND_EVENT_REGISTER, bits);
  endtask : clr1
endmodule : vczx_host
